/* verilog/ldodc_params.svh */
// register offsets, field positions and reset values of the regulator control block
`ifndef LDODC_PARAMS_SVH
`define LDODC_PARAMS_SVH

`define LDODC_ADDR_W          8
`define LDODC_DATA_W          8
`define LDODC_OFS_CTRL        8'hC9
`define LDODC_OFS_IRQ_EN      8'hE7
`define LDODC_OFS_IRQ_PRIO    8'hF7
`define LDODC_OFS_IRQ_STAT    8'hD0
`define LDODC_OFS_IRQ_CLR     8'hD1
`define LDODC_OFS_IRQ_IEN     8'hD2
`define LDODC_BIT_OFF         7
`define LDODC_BIT_RSVD        6
`define LDODC_BIT_LEVEL       4
`define LDODC_BIT_DROP        0
`define LDODC_BIT_DROP_IRQ    0
`define LDODC_BIT_STAT_SET    0
`define LDODC_BIT_STAT_CLR    1
`define LDODC_RST_OFF         1'b0
`define LDODC_RST_LEVEL       1'b1
`define LDODC_RST_IRQ_EN      8'h00
`define LDODC_RST_IRQ_PRIO    8'h00

`endif

/* verilog/ldodc_pkg.sv */
// types shared by the regulator control block
package ldodc_pkg;

  typedef struct packed {
    logic off;
    logic level;
  } ldodc_reg_ctrl_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ldodc_bus_req_s;

endpackage : ldodc_pkg

/* verilog/ldodc_top.sv */
// regulator control, dropout status and dropout interrupt logic
`timescale 1ns/10ps
`include "ldodc_params.svh"

// Summary of operation
// - output level is chosen by one control bit: 2.1 V or 2.6 V
// - regulator comes up enabled after reset; software may switch it off
// - dropout request raised while enabled and supply is below threshold
// - dropout request has no pending flag; it follows the condition directly
// - dropout status bit clears by hardware when the dropout ends
// - level select: 0 gives 2.1 V, 1 gives 2.6 V; resets to 1
// - status bit reads 1 while in or near dropout, else 0
// - off bit: 0 keeps regulator on, 1 switches it off; resets to 0
module ldodc_top
  import ldodc_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       nrst_i,
  input  wire logic       clk_en_i,
  input  wire logic [7:0] bus_addr_i,
  input  wire logic [7:0] bus_wdata_i,
  input  wire logic       bus_wr_i,
  input  wire logic       bus_rd_i,
  output logic      [7:0] bus_rdata_o,
  input  wire logic       supply_drop_i,
  output logic            regulator_off_o,
  output logic            output_level_select_o,
  output logic            drop_irq_o,
  output logic            drop_irq_prio_o,
  output logic            irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  ldodc_bus_req_s  req;
  ldodc_reg_ctrl_s ctrl_q;
  logic [7:0]      irq_en_q;
  logic [7:0]      irq_prio_q;
  logic [2:0]      drop_sync_q;
  logic            drop_q;
  logic            drop_irq_q;
  logic [1:0]      stat_q;
  logic [1:0]      ien_q;
  logic            irq_q;
  logic [7:0]      rdata_q;
  logic [7:0]      rdata_d;
  logic            drop_prev_q;

  assign req = '{addr: bus_addr_i, wdata: bus_wdata_i, wr: bus_wr_i, rd: bus_rd_i};

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  // control register
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_q.off   <= `LDODC_RST_OFF;
      ctrl_q.level <= `LDODC_RST_LEVEL;
    end else if (clk_en_i && req.wr && hit(req.addr, `LDODC_OFS_CTRL)) begin
      ctrl_q.off   <= req.wdata[`LDODC_BIT_OFF];
      ctrl_q.level <= req.wdata[`LDODC_BIT_LEVEL];
    end
  end

  // interrupt enable and priority registers (bit 0 only)
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_en_q   <= `LDODC_RST_IRQ_EN;
      irq_prio_q <= `LDODC_RST_IRQ_PRIO;
    end else if (clk_en_i && req.wr) begin
      if (hit(req.addr, `LDODC_OFS_IRQ_EN)) begin
        irq_en_q <= {7'h00, req.wdata[`LDODC_BIT_DROP_IRQ]};
      end
      if (hit(req.addr, `LDODC_OFS_IRQ_PRIO)) begin
        irq_prio_q <= {7'h00, req.wdata[`LDODC_BIT_DROP_IRQ]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // dropout input: three flops, change accepted when stages 2 and 3 agree
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      drop_sync_q <= 3'h0;
      drop_q      <= 1'b0;
    end else if (clk_en_i) begin
      drop_sync_q <= {drop_sync_q[1:0], supply_drop_i};
      if (drop_sync_q[2] == drop_sync_q[1]) begin
        drop_q <= drop_sync_q[2];
      end
    end
  end

  // level request, no latch
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      drop_irq_q <= 1'b0;
    end else if (clk_en_i) begin
      drop_irq_q <= drop_q & irq_en_q[`LDODC_BIT_DROP_IRQ];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky status: bit0 dropout entered, bit1 dropout ended; set beats clear
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      drop_prev_q <= 1'b0;
      stat_q      <= 2'h0;
      ien_q       <= 2'h0;
    end else if (clk_en_i) begin
      drop_prev_q <= drop_q;
      if (req.wr && hit(req.addr, `LDODC_OFS_IRQ_IEN)) begin
        ien_q <= req.wdata[1:0];
      end
      stat_q <= (stat_q & ~((req.wr && hit(req.addr, `LDODC_OFS_IRQ_CLR)) ?
                            req.wdata[1:0] : 2'h0))
                | {drop_prev_q & ~drop_q, drop_q & ~drop_prev_q};
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_q <= 1'b0;
    end else if (clk_en_i) begin
      irq_q <= |(stat_q & ien_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port, data one cycle after the strobe
  always_comb begin
    rdata_d = 8'h00;
    unique case (1'b1)
      hit(req.addr, `LDODC_OFS_CTRL): begin
        rdata_d[`LDODC_BIT_OFF]   = ctrl_q.off;
        rdata_d[`LDODC_BIT_RSVD]  = 1'b1;
        rdata_d[`LDODC_BIT_LEVEL] = ctrl_q.level;
        rdata_d[`LDODC_BIT_DROP]  = drop_q;
      end
      hit(req.addr, `LDODC_OFS_IRQ_EN):   rdata_d = irq_en_q;
      hit(req.addr, `LDODC_OFS_IRQ_PRIO): rdata_d = irq_prio_q;
      hit(req.addr, `LDODC_OFS_IRQ_STAT): rdata_d = {6'h00, stat_q};
      hit(req.addr, `LDODC_OFS_IRQ_IEN):  rdata_d = {6'h00, ien_q};
      default:                            rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_q <= 8'h00;
    end else if (clk_en_i) begin
      rdata_q <= req.rd ? rdata_d : 8'h00;
    end
  end

  assign bus_rdata_o           = rdata_q;
  assign regulator_off_o       = ctrl_q.off;
  assign output_level_select_o = ctrl_q.level;
  assign drop_irq_o            = drop_irq_q;
  assign drop_irq_prio_o       = irq_prio_q[`LDODC_BIT_DROP_IRQ];
  assign irq_o                 = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  a_irq_follows_drop: assert property (clk_en_i |=>
    drop_irq_o == ($past(drop_q) & $past(irq_en_q[0])))
    else $error("dropout request does not follow condition and enable");
  a_no_pending_flag: assert property ((clk_en_i && !drop_q) |=> !drop_irq_o)
    else $error("dropout request held without condition");
  a_irq_when_enabled: assert property ((clk_en_i && drop_q && irq_en_q[0]) |=> drop_irq_o)
    else $error("dropout request missing while enabled");
  a_drop_clears: assert property ((clk_en_i && !supply_drop_i)[*4] |=> !drop_q)
    else $error("dropout status not cleared after recovery");
  a_drop_sets: assert property ((clk_en_i && supply_drop_i)[*4] |=> drop_q)
    else $error("dropout status not set in dropout");
  a_off_write: assert property ((clk_en_i && req.wr && req.addr == `LDODC_OFS_CTRL)
    |=> regulator_off_o == $past(req.wdata[7]))
    else $error("regulator off bit not written");
  a_level_write: assert property ((clk_en_i && req.wr && req.addr == `LDODC_OFS_CTRL)
    |=> output_level_select_o == $past(req.wdata[4]))
    else $error("output level bit not written");
  a_off_stable: assert property ((!(req.wr && req.addr == `LDODC_OFS_CTRL))
    |=> $stable(regulator_off_o))
    else $error("regulator off bit changed without write");
  a_rd_data: assert property ((clk_en_i && req.rd && req.addr == `LDODC_OFS_CTRL)
    |=> bus_rdata_o[4] == output_level_select_o)
    else $error("level readback wrong");
  a_prio_write: assert property ((clk_en_i && req.wr && req.addr == `LDODC_OFS_IRQ_PRIO)
    |=> drop_irq_prio_o == $past(req.wdata[0]))
    else $error("dropout priority bit not written");
  a_lvl_stable: assert property ((!(req.wr && req.addr == `LDODC_OFS_CTRL))
    |=> $stable(output_level_select_o))
    else $error("output level bit changed without write");
  a_irq_level: assert property (clk_en_i |=>
    irq_o == (|($past(stat_q) & $past(ien_q))))
    else $error("status interrupt does not follow status and enable");
  a_stat_sticky: assert property ((clk_en_i && stat_q[0]
    && !(req.wr && req.addr == `LDODC_OFS_IRQ_CLR)) |=> stat_q[0])
    else $error("dropout status bit lost without clear");
  a_rdata_idle: assert property ((clk_en_i && !req.rd) |=> bus_rdata_o == 8'h00)
    else $error("read data not zero outside read cycle");
  a_freeze_holds: assert property (!clk_en_i
    |=> ($stable(regulator_off_o) && $stable(drop_q) && $stable(stat_q)))
    else $error("state changed while clock enable low");

  // main scenarios
  c_drop_irq: cover property (drop_irq_o);
  c_drop_end: cover property (drop_q ##1 !drop_q);
  c_reg_off:  cover property (regulator_off_o);
  c_irq_out:  cover property (irq_o);
  c_clk_frozen: cover property (!clk_en_i);

endmodule : ldodc_top

/* test/ldodc_core_model.sv */
// core-side bus master model of the regulator control block
`timescale 1ns/10ps
module ldodc_core_model (
  input  wire logic       core_clk_i,
  input  wire logic [7:0] rdata_i,
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o,
  output logic            wr_o,
  output logic            rd_o
);
  initial begin
    addr_o  = 8'h00;
    wdata_o = 8'h00;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge core_clk_i);
    wr_o    <= 1'b0;
    wdata_o <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge core_clk_i);
    rd_o   <= 1'b0;
    #1 d = rdata_i;
  endtask : rd
  // priority first, then enable, written at once with no wait on the supply
  task automatic arm();
    wr(8'hF7, 8'h01);
    wr(8'hE7, 8'h01);
  endtask : arm
  // service routine drops the enable and leaves it off
  task automatic service();
    wr(8'hE7, 8'h00);
  endtask : service
endmodule : ldodc_core_model

/* test/test_ldodc_top.sv */
// self-checking bench of the regulator control block
`timescale 1ns/10ps
module test_ldodc_top;
  logic       core_clk_i, nrst_i, supply_drop_i, wr, rd, off, lvl, dirq, prio, irq, en;
  logic [7:0] addr, wdata, rdata, v;
  int         errors, total_checks, cycles;
  ldodc_core_model ldodc_core_model_i (.core_clk_i(core_clk_i), .rdata_i(rdata),
    .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
  ldodc_top ldodc_top_i (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .clk_en_i(en),
    .bus_addr_i(addr), .bus_wdata_i(wdata), .bus_wr_i(wr), .bus_rd_i(rd),
    .bus_rdata_o(rdata), .supply_drop_i(supply_drop_i), .regulator_off_o(off),
    .output_level_select_o(lvl), .drop_irq_o(dirq), .drop_irq_prio_o(prio), .irq_o(irq));
  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize();
    if (errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    ldodc_core_model_i.rd(a, v);
    check(v, exp);
  endtask : rchk
  task automatic supply(input logic s);
    @(posedge core_clk_i);
    supply_drop_i <= s;
    repeat (6) @(posedge core_clk_i);
    #1;
  endtask : supply
  ////////////////////////////////////////////////////////////
  task automatic t_reset();
    check({off, lvl, dirq, prio, irq}, 8'h08);
    rchk(8'hC9, 8'h50);
  endtask : t_reset
  task automatic t_ctrl();
    ldodc_core_model_i.wr(8'hC9, 8'hD0);
    #1 check({off, lvl}, 8'h03);
    ldodc_core_model_i.wr(8'hC9, 8'h40);
    #1 check({off, lvl}, 8'h00);
    rchk(8'hC9, 8'h40);
    ldodc_core_model_i.wr(8'h33, 8'hFF);
    rchk(8'h33, 8'h00);
    ldodc_core_model_i.wr(8'hC9, 8'h50);
    #1 check({off, lvl}, 8'h01);
  endtask : t_ctrl
  task automatic t_drop();
    ldodc_core_model_i.wr(8'hD2, 8'h03);
    ldodc_core_model_i.arm();
    supply(1'b1);
    check({dirq, prio, irq}, 8'h07);
    rchk(8'hC9, 8'h51);
    ldodc_core_model_i.service();
    @(posedge core_clk_i);
    #1 check(dirq, 1'b0);
    ldodc_core_model_i.arm();
    @(posedge core_clk_i);
    #1 check(dirq, 1'b1);
    supply(1'b0);
    check(dirq, 1'b0);
    rchk(8'hC9, 8'h50);
    rchk(8'hD0, 8'h03);
    ldodc_core_model_i.wr(8'hD2, 8'h00);
    @(posedge core_clk_i);
    #1 check(irq, 1'b0);
    ldodc_core_model_i.wr(8'hD2, 8'h03);
    @(posedge core_clk_i);
    #1 check(irq, 1'b1);
    ldodc_core_model_i.wr(8'hD1, 8'h03);
    @(posedge core_clk_i);
    #1 check(irq, 1'b0);
    rchk(8'hD0, 8'h00);
  endtask : t_drop
  task automatic t_glitch();
    @(posedge core_clk_i);
    supply_drop_i <= 1'b1;
    @(posedge core_clk_i);
    supply_drop_i <= 1'b0;
    repeat (5) @(posedge core_clk_i);
    #1 check({dirq, irq}, 8'h00);
    rchk(8'hD0, 8'h00);
    rchk(8'hC9, 8'h50);
    rchk(8'hE7, 8'h01);
    rchk(8'hF7, 8'h01);
    rchk(8'hD2, 8'h03);
  endtask : t_glitch
  task automatic t_freeze();
    @(posedge core_clk_i);
    en <= 1'b0;
    ldodc_core_model_i.wr(8'hC9, 8'hC0);
    #1 check({off, lvl}, 8'h01);
    supply(1'b1);
    check(dirq, 1'b0);
    @(posedge core_clk_i);
    en <= 1'b1;
    supply(1'b1);
    check({dirq, irq}, 8'h03);
    supply(1'b0);
    check(dirq, 1'b0);
    ldodc_core_model_i.wr(8'hD1, 8'h03);
    rchk(8'hD0, 8'h00);
  endtask : t_freeze
  task automatic t_rereset();
    ldodc_core_model_i.wr(8'hC9, 8'hC0);
    #1 check({off, lvl}, 8'h02);
    @(posedge core_clk_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    #1 check({off, lvl, dirq, prio, irq}, 8'h08);
    rchk(8'hC9, 8'h50);
  endtask : t_rereset
  ////////////////////////////////////////////////////////////
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles > 3000) begin
      errors++;
      summarize();
    end
  end
  initial begin
    nrst_i        = 1'b0;
    supply_drop_i = 1'b0;
    en            = 1'b1;
    repeat (2) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    #1;
    t_reset();
    t_ctrl();
    t_drop();
    t_glitch();
    t_freeze();
    t_rereset();
    summarize();
  end
endmodule : test_ldodc_top
